// ---- alarm_pkg.sv ----
// Package of register map, field positions and timing constants for the E1 alarm detector
package alarm_pkg;
	// Register byte addresses (printed offsets are not multiples of four: index times four)
	localparam logic [11:0] IDX_LIVE_STATE = 12'h0B9;
	localparam logic [11:0] IDX_IRQ_ENABLE = 12'h0BA;
	localparam logic [11:0] IDX_CHANGE_LATCH = 12'h0BB;
	localparam logic [11:0] IDX_CRITERIA_SELECT = 12'h0BC;
	localparam logic [13:0] ADDR_LIVE_STATE = {IDX_LIVE_STATE, 2'h0};
	localparam logic [13:0] ADDR_IRQ_ENABLE = {IDX_IRQ_ENABLE, 2'h0};
	localparam logic [13:0] ADDR_CHANGE_LATCH = {IDX_CHANGE_LATCH, 2'h0};
	localparam logic [13:0] ADDR_CRITERIA_SELECT = {IDX_CRITERIA_SELECT, 2'h0};
	// Alarm bit positions, shared by state, event and enable registers
	localparam int BIT_RED = 0;
	localparam int BIT_RAI = 1;
	localparam int BIT_AIS = 2;
	localparam int BIT_RMAI = 3;
	localparam int BIT_TS16AIS = 4;
	localparam int BIT_TS16LOS = 5;
	localparam int NUM_ALARMS = 6;
	// Criteria select field positions
	localparam int BIT_RAI_SEL = 0;
	localparam int BIT_AIS_SEL = 1;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	localparam logic [31:0] ERR_READ_VALUE = 32'h00000000;
	// Detection thresholds
	localparam logic [4:0] TS16_RUN = 5'h10;
	localparam logic [3:0] TS16_FRAMES = 4'hF;
	localparam logic [4:0] TS16_AIS_MAX_ZEROS = 5'h03;
	localparam logic [1:0] Y_RUN = 2'h3;
	localparam logic [2:0] A_RUN = 3'h4;
	localparam logic [8:0] AIS_WINDOW_LAST = 9'h1FF;
	localparam logic [9:0] AIS_MAX_ZEROS = 10'h002;
	// RED persistence time
	localparam int RED_TIME_MS = 100;
	localparam int CLK_MHZ = 250;
	localparam int RED_CYCLES = RED_TIME_MS * 1000 * CLK_MHZ;
	// Received-bit strobe bundle from the framer
	typedef struct packed {
		logic bit_valid;
		logic bit_value;
		logic frame_sync;
		logic ts16_octet_valid;
		logic [7:0] ts16_octet;
		logic frame_start;
		logic y_valid;
		logic y_value;
		logic a_valid;
		logic a_value;
	} rx_event_s;
endpackage : alarm_pkg

// ---- e1_receive_alarm_detector.sv ----
// E1 receive alarm detector with APB register file and interrupt pin
//
// What this block does
// - TS16 loss: 16 zero octets set, 16 nonzero clear
// - TS16 AIS: under four zeros twice, clear above three
// - Multiframe alarm: three Y ones set, one zero clears
// - AIS sel 0: under three zeros, out of sync
// - AIS sel 1: two windows each to set, clear
// - Remote alarm sel 0: four A ones set
// - Remote alarm sel 1: one A one sets
// - RED after 100 ms out or in sync
// - Any state change latches its event bit
// - Write one clears only those event bits
// - Enable bit gates each event to pin
// - Same bit positions in all three registers
`timescale 1ns/1ps
module e1_receive_alarm_detector
	import alarm_pkg::*;
#(
	parameter int RED_COUNT = RED_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire rx_event_s rx,
	output logic irq_n
);
	// Live alarm states
	logic slot16_loss_state;
	logic slot16_all_ones_state;
	logic remote_multiframe_alarm_state;
	logic all_ones_state;
	logic remote_alarm_state;
	logic frame_loss_alarm_state;
	logic [NUM_ALARMS-1:0] live; // Packed view in register order
	logic [NUM_ALARMS-1:0] live_q; // Previous view for change detection
	logic [NUM_ALARMS-1:0] alarm_change_latch;
	logic [NUM_ALARMS-1:0] alarm_irq_enable;
	logic [1:0] alarm_criteria_select;
	logic all_ones_criterion_sel;
	logic remote_alarm_criterion_sel;
	// Bus decode
	logic access; // Access phase, answered at once
	logic wr_en;
	logic [NUM_ALARMS-1:0] clear_mask;

	assign access = psel && penable;
	assign wr_en = access && pwrite && pstrb[0];
	assign all_ones_criterion_sel = alarm_criteria_select[BIT_AIS_SEL];
	assign remote_alarm_criterion_sel = alarm_criteria_select[BIT_RAI_SEL];
	assign live = {slot16_loss_state, slot16_all_ones_state, remote_multiframe_alarm_state,
		all_ones_state, remote_alarm_state, frame_loss_alarm_state};

	// Write-one-to-clear mask, only on the low byte lane
	always_comb begin
		clear_mask = '0;
		if (wr_en && paddr[13:0] == ADDR_CHANGE_LATCH) begin
			clear_mask = pwdata[NUM_ALARMS-1:0];
		end
	end

	// TS16 loss: count runs of zero and nonzero octets
	logic [4:0] ts16_zero_run;
	logic [4:0] ts16_live_run;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ts16_zero_run <= '0;
			ts16_live_run <= '0;
			slot16_loss_state <= 1'b0;
		end else if (!rx.frame_sync) begin
			// Needs basic frame alignment; restart counts without it
			ts16_zero_run <= '0;
			ts16_live_run <= '0;
		end else if (rx.ts16_octet_valid) begin
			if (rx.ts16_octet == 8'h00) begin
				ts16_live_run <= '0;
				ts16_zero_run <= (ts16_zero_run == TS16_RUN) ? TS16_RUN : ts16_zero_run + 5'h01;
				if (ts16_zero_run + 5'h01 >= TS16_RUN) begin
					slot16_loss_state <= 1'b1;
				end
			end else begin
				ts16_zero_run <= '0;
				ts16_live_run <= (ts16_live_run == TS16_RUN) ? TS16_RUN : ts16_live_run + 5'h01;
				if (ts16_live_run + 5'h01 >= TS16_RUN) begin
					slot16_loss_state <= 1'b0;
				end
			end
		end
	end

	// TS16 AIS: zero count per 16-frame period
	logic [3:0] ts16_frame_cnt;
	logic [7:0] ts16_zero_cnt; // Up to 128 zeros in 16 octets
	logic ts16_low_prev; // Last period had under four zeros
	logic [7:0] ts16_zeros_now;
	logic [7:0] ts16_period_zeros;
	always_comb begin
		ts16_zeros_now = 8'h00;
		for (int i = 0; i < 8; i++) begin
			ts16_zeros_now = ts16_zeros_now + {7'h00, ~rx.ts16_octet[i]};
		end
		ts16_period_zeros = ts16_zero_cnt + ts16_zeros_now;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ts16_frame_cnt <= '0;
			ts16_zero_cnt <= '0;
			ts16_low_prev <= 1'b0;
			slot16_all_ones_state <= 1'b0;
		end else if (!rx.frame_sync) begin
			ts16_frame_cnt <= '0;
			ts16_zero_cnt <= '0;
			ts16_low_prev <= 1'b0;
		end else if (rx.ts16_octet_valid) begin
			if (ts16_frame_cnt == TS16_FRAMES) begin
				ts16_frame_cnt <= '0;
				ts16_zero_cnt <= '0;
				ts16_low_prev <= (ts16_period_zeros <= {3'h0, TS16_AIS_MAX_ZEROS});
				if (ts16_period_zeros > {3'h0, TS16_AIS_MAX_ZEROS}) begin
					slot16_all_ones_state <= 1'b0;
				end else if (ts16_low_prev) begin
					slot16_all_ones_state <= 1'b1;
				end
			end else begin
				ts16_frame_cnt <= ts16_frame_cnt + 4'h1;
				ts16_zero_cnt <= ts16_period_zeros;
			end
		end
	end

	// Remote multiframe alarm from Y bits, one per signalling multiframe
	logic [1:0] y_run;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			y_run <= '0;
			remote_multiframe_alarm_state <= 1'b0;
		end else if (rx.y_valid) begin
			if (!rx.y_value) begin
				y_run <= '0;
				remote_multiframe_alarm_state <= 1'b0;
			end else begin
				y_run <= (y_run == Y_RUN) ? Y_RUN : y_run + 2'h1;
				if (y_run + 2'h1 >= Y_RUN) begin
					remote_multiframe_alarm_state <= 1'b1;
				end
			end
		end
	end

	// AIS: zeros in fixed 512-bit windows of the raw stream
	logic [8:0] ais_bit_cnt;
	logic [9:0] ais_zero_cnt;
	logic ais_low_prev; // Previous window had under three zeros
	logic ais_high_prev; // Previous window had over two zeros
	logic [9:0] ais_window_zeros;
	logic ais_low;
	assign ais_window_zeros = ais_zero_cnt + {9'h000, ~rx.bit_value};
	assign ais_low = ais_window_zeros <= AIS_MAX_ZEROS;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ais_bit_cnt <= '0;
			ais_zero_cnt <= '0;
			ais_low_prev <= 1'b0;
			ais_high_prev <= 1'b0;
			all_ones_state <= 1'b0;
		end else if (rx.bit_valid) begin
			if (ais_bit_cnt == AIS_WINDOW_LAST) begin
				ais_bit_cnt <= '0;
				ais_zero_cnt <= '0;
				ais_low_prev <= ais_low;
				ais_high_prev <= !ais_low;
				if (!all_ones_criterion_sel) begin
					// Single window; declaring also needs loss of alignment
					if (ais_low && !rx.frame_sync) begin
						all_ones_state <= 1'b1;
					end else if (!ais_low) begin
						all_ones_state <= 1'b0;
					end
				end else begin
					if (ais_low && ais_low_prev) begin
						all_ones_state <= 1'b1;
					end else if (!ais_low && ais_high_prev) begin
						all_ones_state <= 1'b0;
					end
				end
			end else begin
				ais_bit_cnt <= ais_bit_cnt + 9'h001;
				ais_zero_cnt <= ais_window_zeros;
			end
		end
	end

	// Remote alarm from A bits in non-alignment frames
	logic [2:0] a_run;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			a_run <= '0;
			remote_alarm_state <= 1'b0;
		end else if (!rx.frame_sync) begin
			a_run <= '0; // A bits mean nothing without alignment
		end else if (rx.a_valid) begin
			if (!rx.a_value) begin
				a_run <= '0;
				remote_alarm_state <= 1'b0;
			end else begin
				a_run <= (a_run == A_RUN) ? A_RUN : a_run + 3'h1;
				if (remote_alarm_criterion_sel || a_run + 3'h1 >= A_RUN) begin
					remote_alarm_state <= 1'b1;
				end
			end
		end
	end

	// RED: persistence timer restarts whenever sync disagrees with the state
	logic [31:0] red_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			red_cnt <= '0;
			frame_loss_alarm_state <= 1'b0;
		end else if (rx.frame_sync != frame_loss_alarm_state) begin
			red_cnt <= '0; // Condition matches present state, nothing pending
		end else if (red_cnt >= RED_COUNT - 1) begin
			red_cnt <= '0;
			frame_loss_alarm_state <= !frame_loss_alarm_state;
		end else begin
			red_cnt <= red_cnt + 32'h1;
		end
	end

	// Event latch: a change in the same cycle as a clear still latches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			live_q <= '0;
			alarm_change_latch <= '0;
		end else begin
			live_q <= live;
			alarm_change_latch <= (alarm_change_latch & ~clear_mask) | (live ^ live_q);
		end
	end

	// Software-written control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_irq_enable <= RESET_VALUE[NUM_ALARMS-1:0];
			alarm_criteria_select <= RESET_VALUE[1:0];
		end else if (wr_en) begin
			if (paddr[13:0] == ADDR_IRQ_ENABLE) begin
				alarm_irq_enable <= pwdata[NUM_ALARMS-1:0];
			end else if (paddr[13:0] == ADDR_CRITERIA_SELECT) begin
				alarm_criteria_select <= pwdata[1:0];
			end
		end
	end

	// Interrupt pin, registered; one cycle behind the latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_n <= 1'b1;
		end else begin
			irq_n <= !(|(alarm_change_latch & alarm_irq_enable));
		end
	end

	// APB read path and answer, zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable; // Ready during the access phase
			pslverr <= 1'b0;
			prdata <= '0;
			if (psel && !penable && !pwrite) begin
				if (paddr[13:0] == ADDR_LIVE_STATE) begin
					prdata <= {26'h0, live};
				end else if (paddr[13:0] == ADDR_IRQ_ENABLE) begin
					prdata <= {26'h0, alarm_irq_enable};
				end else if (paddr[13:0] == ADDR_CHANGE_LATCH) begin
					prdata <= {26'h0, alarm_change_latch};
				end else if (paddr[13:0] == ADDR_CRITERIA_SELECT) begin
					prdata <= {30'h0, alarm_criteria_select};
				end else begin
					prdata <= ERR_READ_VALUE;
				end
			end
		end
	end

	// Checks
	a_pin_follows_enable: assert property (@(posedge pclk) disable iff (!presetn)
		(|(alarm_change_latch & alarm_irq_enable)) |=> !irq_n)
		else $error("irq pin not low with enabled event");
	a_pin_idle_when_masked: assert property (@(posedge pclk) disable iff (!presetn)
		!(|(alarm_change_latch & alarm_irq_enable)) |=> irq_n)
		else $error("irq pin low with no enabled event");
	a_change_sets_event: assert property (@(posedge pclk) disable iff (!presetn)
		(live != live_q) |=> ((alarm_change_latch & ($past(live) ^ $past(live_q))) ==
		($past(live) ^ $past(live_q))))
		else $error("state change missed by event latch");
	a_clear_keeps_others: assert property (@(posedge pclk) disable iff (!presetn)
		(clear_mask != '0) |=> ((alarm_change_latch & ~$past(clear_mask)) ==
		($past(alarm_change_latch) & ~$past(clear_mask))) || (live_q != $past(live_q)))
		else $error("clear touched unwritten event bits");
	a_y_zero_clears: assert property (@(posedge pclk) disable iff (!presetn)
		(rx.y_valid && !rx.y_value) |=> !remote_multiframe_alarm_state)
		else $error("Y zero did not clear alarm");
	a_a_zero_clears: assert property (@(posedge pclk) disable iff (!presetn)
		(rx.frame_sync && rx.a_valid && !rx.a_value) |=> !remote_alarm_state)
		else $error("A zero did not clear remote alarm");
	a_a_one_sets_sel1: assert property (@(posedge pclk) disable iff (!presetn)
		(remote_alarm_criterion_sel && rx.frame_sync && rx.a_valid && rx.a_value)
		|=> remote_alarm_state)
		else $error("A one did not set remote alarm");
	a_red_rises_slow: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(frame_loss_alarm_state) |-> !$past(rx.frame_sync, 2))
		else $error("RED rose while aligned");
	a_ts16_loss_run: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(slot16_loss_state) |-> ts16_zero_run == TS16_RUN)
		else $error("TS16 loss set before 16 zero octets");
endmodule : e1_receive_alarm_detector

// ---- e1_line_model.sv ----
// Behavioural framer and line source that feeds the alarm detector
`timescale 1ns/1ps
module e1_line_model
	import alarm_pkg::*;
(
	input wire logic clk,
	output rx_event_s rx
);
	// Strobes idle low, alignment starts high so no timer runs at once
	initial begin
		rx = '0;
		rx.frame_sync = 1'b1;
	end

	// Alignment level, moved just after a clock edge
	task sync(input logic v);
		@(posedge clk);
		rx.frame_sync <= v;
	endtask : sync

	// One strobe: 0 A bit, 1 Y bit, 2 slot 16 octet
	task put(input int k, input logic [7:0] v);
		@(posedge clk);
		rx.a_valid <= k == 0;
		rx.y_valid <= k == 1;
		rx.ts16_octet_valid <= k == 2;
		rx.frame_start <= k == 2; // Frame marker rides with the slot 16 octet
		rx.a_value <= v[0];
		rx.y_value <= v[0];
		rx.ts16_octet <= v;
		@(posedge clk);
		// Released values flip so a stale level never looks valid
		rx.a_valid <= 1'b0;
		rx.y_valid <= 1'b0;
		rx.ts16_octet_valid <= 1'b0;
		rx.frame_start <= 1'b0;
		rx.a_value <= ~v[0];
		rx.y_value <= ~v[0];
		rx.ts16_octet <= ~v;
	endtask : put

	// One fixed window of 512 line bits holding a run of z zeros
	task window(input int z);
		int p;
		p = $urandom_range(500);
		for (int i = 0; i < 512; i++) begin
			@(posedge clk);
			rx.bit_valid <= 1'b1;
			rx.bit_value <= !(i >= p && i < p + z);
		end
		@(posedge clk);
		rx.bit_valid <= 1'b0;
		rx.bit_value <= ~rx.bit_value;
	endtask : window
endmodule : e1_line_model

// ---- tb_e1_receive_alarm_detector.sv ----
// Self-checking bench for the E1 receive alarm detector
`timescale 1ns/1ps
module tb_e1_receive_alarm_detector
	import alarm_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'hF;
	logic lane0 = 1'b1; // Low byte strobe for the next transfer
	logic err_q; // Last error response
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq_n;
	rx_event_s rx;
	logic [31:0] q; // Last read data
	logic [31:0] r; // Random write value
	logic [13:0] regs [4] = '{ADDR_LIVE_STATE, ADDR_IRQ_ENABLE, ADDR_CHANGE_LATCH,
		ADDR_CRITERIA_SELECT};
	int bad_count = 0;
	int tests_run = 0;
	int cyc = 0;

	// Short RED timer keeps the run brief
	e1_receive_alarm_detector #(.RED_COUNT(20)) DUT (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx(rx),
		.irq_n(irq_n));
	e1_line_model lm (.clk(pclk), .rx(rx));

	// Clock at 250 MHz
	initial begin
		forever #2 pclk = ~pclk;
	end

	// Hang guard, well above the few thousand cycles the tests need
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			close_out();
		end
	end

	// Compare and count
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; request held until pready is seen high
	task apb(input logic w, input logic [13:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'($urandom), a}; // Upper address bits are ignored
		pwdata <= d;
		pstrb <= {3'($urandom), lane0};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Read and compare
	task rd(input logic [13:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(q, e);
		chk({31'h0, err_q}, 32'h0);
	endtask : rd

	// Pin level after the two registered stages settle
	task pin(input logic e);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq_n}, {31'h0, e});
	endtask : pin

	// Mask of one alarm position
	function logic [31:0] m(input int b);
		return 32'h1 << b;
	endfunction : m

	// Verdict and end of run
	task close_out;
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out

	// Main sequence
	initial begin
		void'($urandom(32'hF059));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, unmapped place and access kinds
		for (int i = 0; i < 4; i++) rd(regs[i], 32'h0);
		rd(14'h0300, 32'h0);
		r = $urandom;
		apb(1'b1, ADDR_IRQ_ENABLE, r);
		rd(ADDR_IRQ_ENABLE, r & 32'h3F);
		apb(1'b1, ADDR_CRITERIA_SELECT, r);
		rd(ADDR_CRITERIA_SELECT, r & 32'h3);
		apb(1'b1, ADDR_LIVE_STATE, r);
		rd(ADDR_LIVE_STATE, 32'h0);
		apb(1'b1, ADDR_IRQ_ENABLE, 32'h0);
		apb(1'b1, ADDR_CRITERIA_SELECT, 32'h0);
		// Writes without the low byte strobe are dropped
		lane0 = 1'b0;
		apb(1'b1, ADDR_IRQ_ENABLE, 32'h3F);
		lane0 = 1'b1;
		rd(ADDR_IRQ_ENABLE, 32'h0);
		$display("registers done");
		// Remote alarm needs four ones in a row
		repeat (3) lm.put(0, 8'h01);
		rd(ADDR_LIVE_STATE, 32'h0);
		lm.put(0, 8'h01);
		rd(ADDR_LIVE_STATE, m(BIT_RAI));
		lm.put(0, 8'h00);
		rd(ADDR_LIVE_STATE, 32'h0);
		rd(ADDR_CHANGE_LATCH, m(BIT_RAI));
		pin(1'b1);
		apb(1'b1, ADDR_IRQ_ENABLE, m(BIT_RAI));
		pin(1'b0);
		apb(1'b1, ADDR_CHANGE_LATCH, m(BIT_RAI));
		pin(1'b1);
		$display("remote alarm done");
		// Multiframe alarm, then single-bit remote alarm
		repeat (2) lm.put(1, 8'h01);
		rd(ADDR_LIVE_STATE, 32'h0);
		lm.put(1, 8'h01);
		rd(ADDR_LIVE_STATE, m(BIT_RMAI));
		lm.put(1, 8'h00);
		apb(1'b1, ADDR_CRITERIA_SELECT, m(BIT_RAI_SEL));
		lm.put(0, 8'h01);
		rd(ADDR_LIVE_STATE, m(BIT_RAI));
		rd(ADDR_CHANGE_LATCH, m(BIT_RAI) | m(BIT_RMAI));
		apb(1'b1, ADDR_CHANGE_LATCH, m(BIT_RAI));
		rd(ADDR_CHANGE_LATCH, m(BIT_RMAI));
		lm.put(0, 8'h00);
		rd(ADDR_LIVE_STATE, 32'h0);
		apb(1'b1, ADDR_CHANGE_LATCH, 32'h3F);
		$display("multiframe done");
		// Slot 16 loss, then all-ones periods with 0, 3 and 7 zeros
		repeat (15) lm.put(2, 8'h00);
		rd(ADDR_LIVE_STATE, 32'h0);
		lm.put(2, 8'h00);
		rd(ADDR_LIVE_STATE, m(BIT_TS16LOS));
		repeat (16) lm.put(2, 8'($urandom | 1) & 8'h7F);
		rd(ADDR_LIVE_STATE, 32'h0);
		for (int j = 0; j < 3; j++) begin
			for (int i = 0; i < 16; i++) lm.put(2, (i < j * 3 + j / 2) ? 8'hFE : 8'hFF);
			rd(ADDR_LIVE_STATE, (j == 1) ? m(BIT_TS16AIS) : 32'h0);
		end
		apb(1'b1, ADDR_CHANGE_LATCH, 32'h3F);
		$display("slot 16 done");
		// RED persistence and one-window AIS while out of alignment
		apb(1'b1, ADDR_CRITERIA_SELECT, 32'h0);
		lm.sync(1'b0);
		rd(ADDR_LIVE_STATE, 32'h0);
		repeat (20) @(posedge pclk);
		rd(ADDR_LIVE_STATE, m(BIT_RED));
		lm.window(2);
		rd(ADDR_LIVE_STATE, m(BIT_RED) | m(BIT_AIS));
		lm.window(3);
		rd(ADDR_LIVE_STATE, m(BIT_RED));
		lm.sync(1'b1);
		rd(ADDR_LIVE_STATE, m(BIT_RED));
		repeat (20) @(posedge pclk);
		rd(ADDR_LIVE_STATE, 32'h0);
		$display("red and ais done");
		// Two-window AIS criterion while aligned
		apb(1'b1, ADDR_CRITERIA_SELECT, m(BIT_AIS_SEL));
		lm.window(1);
		rd(ADDR_LIVE_STATE, 32'h0);
		lm.window(0);
		rd(ADDR_LIVE_STATE, m(BIT_AIS));
		lm.window(5);
		rd(ADDR_LIVE_STATE, m(BIT_AIS));
		lm.window(3);
		rd(ADDR_LIVE_STATE, 32'h0);
		// Latched RED and AIS events stay off the pin until enabled
		pin(1'b1);
		apb(1'b1, ADDR_IRQ_ENABLE, 32'h3F);
		pin(1'b0);
		$display("two-window ais done");
		close_out();
	end
endmodule : tb_e1_receive_alarm_detector
